// file: hdl/spm_consts.svh
`ifndef SPM_CONSTS_SVH
`define SPM_CONSTS_SVH
// pull-up register bit positions
`define SPM_PUR_C_INDEX 6
`define SPM_PUR_C_HOME 7
`define SPM_PUR_E_SCLK 4
`define SPM_PUR_E_MOSI 5
`define SPM_PUR_E_MISO 6
`define SPM_PUR_E_SS 7
// reset values
`define SPM_PUR_RST 8'hff
`define SPM_FSEL_C_RST 2'h0
`define SPM_FSEL_E_RST 1'h0
`define SPM_GPIO_RST 1'h0
`endif

// file: hdl/spm_pkg.sv
package spm_pkg;
   // port c pin function, 2 bits, primary first
   typedef enum logic [1:0] {
      SPM_C_PRIMARY = 2'h0,
      SPM_C_TIMER = 2'h1,
      SPM_C_GPIO = 2'h2
   } spm_cfunc_t;
   // spi role states, one-hot
   typedef enum logic [2:0] {
      SPM_ST_IDLE = 3'h1,
      SPM_ST_MASTER = 3'h2,
      SPM_ST_SLAVE = 3'h4
   } spm_role_t;
   typedef struct packed {
      logic [7:0] pur_c;
      logic [7:0] pur_e;
      logic [1:0] fsel_c6;
      logic [1:0] fsel_c7;
      logic [3:0] fsel_e;
      spm_role_t role;
      logic [5:0] pin_out;
      logic [5:0] pin_oe_n;
      logic [5:0] pull_en;
      logic dec_index;
      logic dec_home;
      logic tmr_ch2_in;
      logic tmr_ch3_in;
      logic spi_sclk_in;
      logic spi_mosi_in;
      logic spi_miso_in;
      logic spi_ss_n_in;
      logic [5:0] gpio_in;
   } spm_state_t;
endpackage

// file: hdl/spm_pin_mux.sv
`timescale 1ns/1ns
`default_nettype none
`include "spm_consts.svh"
// Functional notes
// - pin c6 defaults to decoder index
// - pin c7 defaults to decoder home
// - pin e4 defaults to spi clock
// - pin e5 defaults to spi master out
// - pin e6 defaults to spi master in
// - pin e7 defaults to spi slave select
// - port c bits 6,7 clear pull-ups
// - port e bits 4,5 clear pull-ups
// - port e bits 6,7 clear pull-ups
// - gpio pins individually input or output
// - spi clock out in master, in slave
// - master drives mosi, slave receives it
// - master data leads sampling edge half period
// - master receives miso, slave drives it
// - unselected slave releases miso
// - slave data leads sampling edge half period
// - slave select marks transfer for us
module spm_pin_mux (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clk_en,
   // pull-up control writes
   input wire logic pur_c_we,
   input wire logic [7:0] pur_c_wdata,
   input wire logic pur_e_we,
   input wire logic [7:0] pur_e_wdata,
   // function select: c6, c7 (spm_cfunc_t), e4..e7 (1 = gpio)
   input wire spm_pkg::spm_cfunc_t fsel_c6,
   input wire spm_pkg::spm_cfunc_t fsel_c7,
   input wire logic [3:0] fsel_e,
   input wire logic fsel_we,
   // gpio: order c6,c7,e4,e5,e6,e7
   input wire logic [5:0] gpio_out,
   input wire logic [5:0] gpio_dir_out,
   output logic [5:0] gpio_in,
   // timer a channels 2 and 3
   input wire logic tmr_ch2_out,
   input wire logic tmr_ch2_oe,
   input wire logic tmr_ch3_out,
   input wire logic tmr_ch3_oe,
   output logic tmr_ch2_in,
   output logic tmr_ch3_in,
   // spi core side
   input wire logic spi_enable,
   input wire logic spi_master,
   input wire logic spi_sclk_out,
   input wire logic spi_mosi_out,
   input wire logic spi_miso_out,
   output logic spi_sclk_in,
   output logic spi_mosi_in,
   output logic spi_miso_in,
   output logic spi_ss_n_in,
   // decoder side
   output logic dec_index,
   output logic dec_home,
   // pads, order c6,c7,e4,e5,e6,e7; oe_n low = driving
   input wire logic [5:0] pad_in,
   output logic [5:0] pad_out,
   output logic [5:0] pad_oe_n,
   output logic [5:0] pad_pull_en,
   output logic [7:0] pur_c,
   output logic [7:0] pur_e
);
   import spm_pkg::*;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // gpio drive enable for one pin, used for all six
   // direction high means output, which pulls oe_n low;
   // one function keeps the six gpio paths from drifting apart
   function automatic logic gpio_oe_n(input logic dir);
      gpio_oe_n = ~dir;
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   // one packed record holds every flop of the block
   spm_state_t s_q, s_d;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   // pad vector order, shared by every six-bit port:
   //    bit 0 - c6: decoder index, timer ch2 or gpio
   //    bit 1 - c7: decoder home, timer ch3 or gpio
   //    bit 2 - e4: spi clock or gpio
   //    bit 3 - e5: spi master out or gpio
   //    bit 4 - e6: spi master in or gpio
   //    bit 5 - e7: spi slave select or gpio
   // pads are sampled as synchronous inputs; all outputs are registered,
   // so every pin path carries one cycle of latency
   always_comb begin
      s_d = s_q;
      // register loads; a cleared bit turns that pull-up off
      if (pur_c_we) begin
         s_d.pur_c = pur_c_wdata;
      end
      if (pur_e_we) begin
         s_d.pur_e = pur_e_wdata;
      end
      // one strobe loads the select of all six pins
      if (fsel_we) begin
         s_d.fsel_c6 = fsel_c6;
         s_d.fsel_c7 = fsel_c7;
         s_d.fsel_e = fsel_e;
      end

      // spi role follows core configuration; roles at the pads:
      //    idle - clock, data and select pads all listen
      //    master - drives clock and master out, hears master in
      //    slave - hears clock and master out, drives master in
      //       only while select is low on its own pin
      // master and slave may swap directly without passing idle
      case (s_q.role)
         SPM_ST_IDLE: begin
            if (spi_enable) begin
               s_d.role = spi_master ? SPM_ST_MASTER : SPM_ST_SLAVE;
            end
         end
         SPM_ST_MASTER, SPM_ST_SLAVE: begin
            if (!spi_enable) begin
               s_d.role = SPM_ST_IDLE;
            end else begin
               s_d.role = spi_master ? SPM_ST_MASTER : SPM_ST_SLAVE;
            end
         end
         // a stray code, never reached by design, falls back to idle
         default: begin
            s_d.role = SPM_ST_IDLE;
         end
      endcase

      // pull-up enables from register bits; taken from s_d so a
      // write shows on the pull enables at the same edge
      s_d.pull_en[0] = s_d.pur_c[`SPM_PUR_C_INDEX];
      s_d.pull_en[1] = s_d.pur_c[`SPM_PUR_C_HOME];
      s_d.pull_en[2] = s_d.pur_e[`SPM_PUR_E_SCLK];
      s_d.pull_en[3] = s_d.pur_e[`SPM_PUR_E_MOSI];
      s_d.pull_en[4] = s_d.pur_e[`SPM_PUR_E_MISO];
      s_d.pull_en[5] = s_d.pur_e[`SPM_PUR_E_SS];
      // gpio sees every pad; harmless when another function owns it
      s_d.gpio_in = pad_in;
      // default: all pads released
      s_d.pin_out = '0;
      s_d.pin_oe_n = '1;

      // pin c6: decoder index, timer ch2 or gpio; the decoder and timer
      // inputs read zero unless they own the pin, so no stale edge leaks through
      s_d.dec_index = 1'h0;
      s_d.tmr_ch2_in = 1'h0;
      case (s_q.fsel_c6)
         SPM_C_PRIMARY: s_d.dec_index = pad_in[0];
         SPM_C_TIMER: begin
            s_d.tmr_ch2_in = pad_in[0];
            s_d.pin_out[0] = tmr_ch2_out;
            s_d.pin_oe_n[0] = ~tmr_ch2_oe;
         end
         SPM_C_GPIO: begin
            s_d.pin_out[0] = gpio_out[0];
            s_d.pin_oe_n[0] = gpio_oe_n(gpio_dir_out[0]);
         end
         // code 3 is unused and falls back to the primary function
         default: begin
            s_d.dec_index = pad_in[0];
         end
      endcase

      // pin c7: decoder home, timer ch3 or gpio
      s_d.dec_home = 1'h0;
      s_d.tmr_ch3_in = 1'h0;
      case (s_q.fsel_c7)
         SPM_C_PRIMARY: s_d.dec_home = pad_in[1];
         SPM_C_TIMER: begin
            s_d.tmr_ch3_in = pad_in[1];
            s_d.pin_out[1] = tmr_ch3_out;
            s_d.pin_oe_n[1] = ~tmr_ch3_oe;
         end
         SPM_C_GPIO: begin
            s_d.pin_out[1] = gpio_out[1];
            s_d.pin_oe_n[1] = gpio_oe_n(gpio_dir_out[1]);
         end
         // code 3 is unused and falls back to the primary function
         default: begin
            s_d.dec_home = pad_in[1];
         end
      endcase

      // spi inputs idle: clock low, select inactive (high)
      s_d.spi_sclk_in = 1'h0;
      s_d.spi_mosi_in = 1'h0;
      s_d.spi_miso_in = 1'h0;
      s_d.spi_ss_n_in = 1'h1;

      // pin e4: spi clock; idle and slave roles both listen here
      if (!s_q.fsel_e[0]) begin
         if (s_q.role == SPM_ST_MASTER) begin
            s_d.pin_out[2] = spi_sclk_out;
            s_d.pin_oe_n[2] = 1'h0;
         end else begin
            s_d.spi_sclk_in = pad_in[2];
         end
      end

      // pin e5: master out / slave in
      if (!s_q.fsel_e[1]) begin
         if (s_q.role == SPM_ST_MASTER) begin
            // core sets data a half period early; same-cycle skew
            // with the clock pad keeps that lead intact
            s_d.pin_out[3] = spi_mosi_out;
            s_d.pin_oe_n[3] = 1'h0;
         end else begin
            s_d.spi_mosi_in = pad_in[3];
         end
      end

      // pin e7: slave select, input only in spi function
      // miso below reads the raw pad rather than this flop, so the
      // release lines up with the one cycle every other pin takes
      if (!s_q.fsel_e[3]) begin
         s_d.spi_ss_n_in = pad_in[5];
      end

      // pin e6: master in / slave out
      if (!s_q.fsel_e[2]) begin
         if (s_q.role == SPM_ST_SLAVE) begin
            // drive only while selected; select must be on its pin
            if (!s_q.fsel_e[3] && !pad_in[5]) begin
               s_d.pin_out[4] = spi_miso_out;
               s_d.pin_oe_n[4] = 1'h0;
            end // else released
         end else begin
            s_d.spi_miso_in = pad_in[4];
         end
      end

      // gpio owners of port e pins; gpio ownership overrides the
      // spi decisions above, whatever the role
      for (int i = 0; i < 4; i++) begin
         if (s_q.fsel_e[i]) begin
            s_d.pin_out[i + 2] = gpio_out[i + 2];
            s_d.pin_oe_n[i + 2] = gpio_oe_n(gpio_dir_out[i + 2]);
         end
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      // reset wins over clk_en so a frozen block still recovers;
      // constants only, nothing sampled enters on this branch
      if (reset) begin
         s_q.pur_c <= `SPM_PUR_RST;
         s_q.pur_e <= `SPM_PUR_RST;
         s_q.fsel_c6 <= `SPM_FSEL_C_RST;
         s_q.fsel_c7 <= `SPM_FSEL_C_RST;
         s_q.fsel_e <= {4{`SPM_FSEL_E_RST}};
         s_q.role <= SPM_ST_IDLE;
         s_q.pin_out <= '0;
         s_q.pin_oe_n <= '1;
         s_q.pull_en <= '1;
         s_q.dec_index <= 1'h0;
         s_q.dec_home <= 1'h0;
         s_q.tmr_ch2_in <= 1'h0;
         s_q.tmr_ch3_in <= 1'h0;
         s_q.spi_sclk_in <= 1'h0;
         s_q.spi_mosi_in <= 1'h0;
         s_q.spi_miso_in <= 1'h0;
         s_q.spi_ss_n_in <= 1'h1;
         s_q.gpio_in <= {6{`SPM_GPIO_RST}};
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------
   // outputs, all from flops
   // ----------------------------------------
   // plain copies; no gate sits between a flop and its port
   assign gpio_in = s_q.gpio_in;
   assign tmr_ch2_in = s_q.tmr_ch2_in;
   assign tmr_ch3_in = s_q.tmr_ch3_in;
   assign spi_sclk_in = s_q.spi_sclk_in;
   assign spi_mosi_in = s_q.spi_mosi_in;
   assign spi_miso_in = s_q.spi_miso_in;
   assign spi_ss_n_in = s_q.spi_ss_n_in;
   assign dec_index = s_q.dec_index;
   assign dec_home = s_q.dec_home;
   assign pad_out = s_q.pin_out;
   assign pad_oe_n = s_q.pin_oe_n;
   assign pad_pull_en = s_q.pull_en;
   assign pur_c = s_q.pur_c;
   assign pur_e = s_q.pur_e;
endmodule
`default_nettype wire

// file: sim/spm_pin_mux_chk.sv
`timescale 1ns/1ns
`default_nettype none
module spm_pin_mux_chk (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic pur_c_we,
   input wire logic [7:0] pur_c_wdata,
   input wire logic [3:0] fsel_e,
   input wire logic fsel_we,
   input wire logic [5:0] gpio_dir_out,
   input wire logic spi_enable,
   input wire logic spi_master,
   input wire logic spi_sclk_out,
   input wire logic spi_miso_out,
   input wire logic [5:0] pad_in,
   input wire logic [5:0] pad_out,
   input wire logic [5:0] pad_oe_n,
   input wire logic [5:0] pad_pull_en,
   input wire logic [7:0] pur_c,
   input wire logic [7:0] pur_e,
   input wire logic [5:0] gpio_in,
   input wire logic spi_ss_n_in
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   // port e selection as held inside; the input alone can differ
   logic [3:0] fsel_e_q;
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         fsel_e_q <= 4'h0;
      end else if (clk_en && fsel_we) begin
         fsel_e_q <= fsel_e;
      end
   end
   // ----------------------------------------
   // pull-ups and sampled inputs
   // ----------------------------------------
   a_pull_map: assert property (
      pad_pull_en == {pur_e[7:4], pur_c[7:6]})
      else $error("pull enable mismatch");
   a_pur_load: assert property (
      clk_en && pur_c_we |=> pur_c == $past(pur_c_wdata))
      else $error("pull-up write lost");
   a_freeze_hold: assert property (
      !clk_en |=> $stable(pur_c) && $stable(pad_oe_n))
      else $error("state moved while frozen");
   a_gpio_sample: assert property (
      $past(clk_en) && !$past(reset) |-> gpio_in == $past(pad_in))
      else $error("gpio input not sampled");
   a_select_path: assert property (
      $past(clk_en) && !$past(reset) && !spi_ss_n_in |-> !$past(pad_in[5]))
      else $error("select low without pin low");
   // ----------------------------------------
   // spi pin drive by role
   // ----------------------------------------
   // two high samples of select cover either latency reading
   a_miso_release: assert property (
      $past(pad_in[5], 1) && $past(pad_in[5], 2) && !$past(gpio_dir_out[4])
      |-> pad_oe_n[4])
      else $error("miso driven while unselected");
   a_master_clock: assert property (
      (spi_enable && spi_master && fsel_e_q == 4'h0 && clk_en) [*3]
      |-> !pad_oe_n[2] && pad_out[2] == $past(spi_sclk_out))
      else $error("master clock not driven");
   a_slave_miso: assert property (
      (spi_enable && !spi_master && fsel_e_q == 4'h0 && clk_en && !pad_in[5])
      [*3] |-> !pad_oe_n[4] && pad_oe_n[2] && pad_out[4] == $past(spi_miso_out))
      else $error("slave miso not driven");
   c_pur_write: cover property (clk_en && pur_c_we);
   c_slave_drive: cover property (spi_enable && !pad_oe_n[4]);
   c_master_drive: cover property (spi_master && !pad_oe_n[2]);
endmodule
bind spm_pin_mux spm_pin_mux_chk u_chk (.ref_clk, .reset, .clk_en, .pur_c_we,
   .pur_c_wdata, .fsel_e, .fsel_we, .gpio_dir_out, .spi_enable, .spi_master,
   .spi_sclk_out, .spi_miso_out, .pad_in, .pad_out, .pad_oe_n, .pad_pull_en,
   .pur_c, .pur_e, .gpio_in, .spi_ss_n_in);
`default_nettype wire

// file: sim/spm_peer.sv
`timescale 1ns/1ns
`default_nettype none
module spm_peer (
   input wire logic ref_clk,
   input wire logic enc_on,
   input wire logic peer_master,
   input wire logic peer_sel,
   input wire logic [5:0] val,
   input wire logic [5:0] pad_out,
   input wire logic [5:0] pad_oe_n,
   input wire logic [5:0] pad_pull_en,
   output logic [5:0] pad_in
);
   logic [5:0] drv;
   logic [5:0] wander_q = 6'h00;
   // --------------------------------
   // which lines the far side drives
   // --------------------------------
   assign drv[1:0] = {2{enc_on}}; // encoder index and home
   assign drv[3:2] = {2{peer_master}};
   assign drv[4] = peer_sel & ~peer_master;
   assign drv[5] = peer_master;
   // device wins, then peer, then pull-up; else the line wanders
   always_comb begin
      for (int k = 0; k < 6; k++) begin
         if (!pad_oe_n[k])
            pad_in[k] = pad_out[k];
         else if (drv[k])
            pad_in[k] = val[k];
         else if (pad_pull_en[k])
            pad_in[k] = 1'b1;
         else
            pad_in[k] = wander_q[k];
      end
   end
   // floating level flips so no stale value can pass
   always_ff @(posedge ref_clk) wander_q <= ~wander_q;
endmodule
`default_nettype wire

// file: sim/spm_pin_mux_bench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
   fail_count++; $display("wrong value %s exp %0h got %0h", n, e, g); end end
module spm_pin_mux_bench;
   import spm_pkg::*;
   logic ref_clk = 0, reset = 1, clk_en = 1, pur_c_we = 0, pur_e_we = 0;
   logic fsel_we = 0, enc_on = 0, peer_master = 0, peer_sel = 0;
   logic tmr_ch2_out = 0, tmr_ch2_oe = 0, tmr_ch3_out = 0, tmr_ch3_oe = 0;
   logic spi_enable = 0, spi_master = 0;
   logic spi_sclk_out = 0, spi_mosi_out = 0, spi_miso_out = 0;
   logic [7:0] pur_c_wdata = 8'hff, pur_e_wdata = 8'hff;
   logic [3:0] fsel_e = 4'h0;
   logic [5:0] gpio_out = 6'h00, gpio_dir_out = 6'h00, val = 6'h00;
   spm_cfunc_t fsel_c6 = SPM_C_PRIMARY, fsel_c7 = SPM_C_PRIMARY;
   wire logic [5:0] gpio_in, pad_in, pad_out, pad_oe_n, pad_pull_en;
   wire logic [7:0] pur_c, pur_e;
   wire logic tmr_ch2_in, tmr_ch3_in, spi_sclk_in, spi_mosi_in;
   wire logic spi_miso_in, spi_ss_n_in, dec_index, dec_home;
   int fail_count = 0, checks_done = 0, pos;
   spm_pin_mux DUT (.ref_clk, .reset, .clk_en, .pur_c_we, .pur_c_wdata,
      .pur_e_we, .pur_e_wdata, .fsel_c6, .fsel_c7, .fsel_e, .fsel_we,
      .gpio_out, .gpio_dir_out, .gpio_in, .tmr_ch2_out, .tmr_ch2_oe,
      .tmr_ch3_out, .tmr_ch3_oe, .tmr_ch2_in, .tmr_ch3_in, .spi_enable,
      .spi_master, .spi_sclk_out, .spi_mosi_out, .spi_miso_out, .spi_sclk_in,
      .spi_mosi_in, .spi_miso_in, .spi_ss_n_in, .dec_index, .dec_home,
      .pad_in, .pad_out, .pad_oe_n, .pad_pull_en, .pur_c, .pur_e);
   spm_peer u_peer (.ref_clk, .enc_on, .peer_master, .peer_sel, .val,
      .pad_out, .pad_oe_n, .pad_pull_en, .pad_in);
   // ----------------------------------------
   // clock, access tasks, verdict
   // ----------------------------------------
   always #20 ref_clk = ~ref_clk;
   // inputs move 2 ns after the edge so sampling never races
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask
   task automatic wr_pur(input logic [7:0] c, input logic [7:0] e);
      pur_c_wdata = c;
      pur_e_wdata = e;
      pur_c_we = 1;
      pur_e_we = 1;
      tick(1);
      pur_c_we = 0;
      pur_e_we = 0;
      tick(1);
   endtask
   task automatic wr_fsel(input spm_cfunc_t c6, input spm_cfunc_t c7,
         input logic [3:0] e);
      fsel_c6 = c6;
      fsel_c7 = c7;
      fsel_e = e;
      fsel_we = 1;
      tick(1);
      fsel_we = 0;
      tick(1);
   endtask
   task automatic stop_test;
      if (fail_count == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // hang guard
   initial begin
      #200000;
      fail_count++;
      stop_test();
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      tick(20);
      reset = 0;
      `CHK("pur_c", 8'hff, pur_c)
      `CHK("pur_e", 8'hff, pur_e)
      `CHK("pull_en", 6'h3f, pad_pull_en)
      `CHK("oe_n", 6'h3f, pad_oe_n)
      // slave role, peer is master and selects us
      spi_enable = 1;
      spi_miso_out = 1;
      enc_on = 1;
      peer_master = 1;
      val = 6'b001111;
      tick(3);
      `CHK("index", 1'b1, dec_index)
      `CHK("home", 1'b1, dec_home)
      `CHK("sclk_in", 1'b1, spi_sclk_in)
      `CHK("mosi_in", 1'b1, spi_mosi_in)
      `CHK("ss_n_in", 1'b0, spi_ss_n_in)
      `CHK("miso oe_n", 1'b0, pad_oe_n[4])
      `CHK("miso out", 1'b1, pad_out[4])
      `CHK("tmr2_in", 1'b0, tmr_ch2_in)
      val = 6'b100000;
      tick(3);
      `CHK("miso oe_n", 1'b1, pad_oe_n[4])
      `CHK("sclk oe_n", 2'b11, pad_oe_n[3:2])
      `CHK("sclk_in", 1'b0, spi_sclk_in)
      `CHK("ss_n_in", 1'b1, spi_ss_n_in)
      `CHK("index", 1'b0, dec_index)
      // master role, peer is a selected slave
      peer_master = 0;
      peer_sel = 1;
      spi_master = 1;
      spi_sclk_out = 1;
      val = 6'b010000;
      tick(3);
      `CHK("spi oe_n", 3'b100, pad_oe_n[4:2])
      `CHK("spi out", 2'b01, pad_out[3:2])
      `CHK("miso_in", 1'b1, spi_miso_in)
      spi_sclk_out = 0;
      spi_mosi_out = 1;
      val = 6'h00;
      tick(1);
      `CHK("spi out", 2'b10, pad_out[3:2])
      `CHK("miso_in", 1'b0, spi_miso_in)
      // one pull-up off at a time; low port e bits have no pin
      spi_enable = 0;
      peer_sel = 0;
      enc_on = 0;
      for (int k = 0; k < 6; k++) begin
         pos = (k < 2) ? k + 6 : k + 2;
         if (k < 2)
            wr_pur(~(8'h01 << pos), 8'hf0);
         else
            wr_pur(8'hff, ~(8'h01 << pos));
         `CHK("pull", 6'h3f & ~(6'h01 << k), pad_pull_en)
      end
      wr_pur(8'hff, 8'hff);
      // alternate functions: timer on c6, gpio elsewhere
      tmr_ch2_out = 1;
      tmr_ch2_oe = 1;
      gpio_out = 6'b010110;
      gpio_dir_out = 6'b010110;
      wr_fsel(SPM_C_TIMER, SPM_C_GPIO, 4'hf);
      tick(1);
      `CHK("oe_n", 6'b101000, pad_oe_n)
      `CHK("out", 6'b010111, pad_out & ~pad_oe_n)
      `CHK("tmr2_in", 1'b1, tmr_ch2_in)
      `CHK("index", 1'b0, dec_index)
      `CHK("gpio_in", 6'h3f, gpio_in)
      `CHK("ss_n_in", 1'b1, spi_ss_n_in)
      gpio_dir_out = 6'h00;
      tmr_ch2_oe = 0;
      tick(1);
      `CHK("oe_n", 6'h3f, pad_oe_n)
      // timer on c7: driven low, then released to its pull-up
      tmr_ch3_out = 0;
      tmr_ch3_oe = 1;
      wr_fsel(SPM_C_GPIO, SPM_C_TIMER, 4'h0);
      tick(1);
      `CHK("oe_n", 6'h3d, pad_oe_n)
      `CHK("tmr3_in", 1'b0, tmr_ch3_in)
      `CHK("tmr2_in", 1'b0, tmr_ch2_in)
      tmr_ch3_oe = 0;
      tick(2);
      `CHK("tmr3_in", 1'b1, tmr_ch3_in)
      `CHK("home", 1'b0, dec_home)
      // frozen enable, then reset in mid-run
      wr_pur(8'h00, 8'h0f);
      `CHK("pull", 6'h00, pad_pull_en)
      clk_en = 0;
      wr_pur(8'hff, 8'hff);
      `CHK("pur_c", 8'h00, pur_c)
      clk_en = 1;
      reset = 1;
      tick(2);
      reset = 0;
      `CHK("pur_c", 8'hff, pur_c)
      `CHK("pull_en", 6'h3f, pad_pull_en)
      enc_on = 1;
      val = 6'h03;
      tick(2);
      `CHK("index", 1'b1, dec_index)
      `CHK("home", 1'b1, dec_home)
      // unused select code 3 must behave as the primary function
      wr_fsel(spm_cfunc_t'(2'h3), spm_cfunc_t'(2'h3), 4'h0);
      tick(1);
      `CHK("index", 1'b1, dec_index)
      `CHK("home", 1'b1, dec_home)
      stop_test();
   end
endmodule
`default_nettype wire
